// ==== hdl/fsl_pkg.sv ====
// constants, types and timing for the flash command host controller
// assumes a 40 MHz mclk and a flash device driven over its parallel pins
// How it works
// - while suspended only read array elsewhere, read status and resume go out
// - reset, write-protect and byte-select levels are frozen during suspend
// - set protection bit: setup then confirm write, then poll for ready
// - after set protection bit check program error, clear status on error
// - clear protection bits: setup then confirm write, then poll for ready
// - after clear protection bits check erase error, clear status on error
// - an aborted clear leaves protection unknown until a clear succeeds
// - configuration is command then code, only with reset/power-down high
package fsl_pkg;
   // status byte bit positions
   localparam int BIT_LOCK_VIOL  = 1;
   localparam int BIT_WR_SUSP    = 2;
   localparam int BIT_SUPPLY_LOW = 3;
   localparam int BIT_PROG_ERR   = 4;
   localparam int BIT_ERASE_ERR  = 5;
   localparam int BIT_READY      = 7;

   // status pin configuration codes
   localparam logic [1:0] STS_LEVEL       = 2'h0;
   localparam logic [1:0] STS_PULSE_ERASE = 2'h1;
   localparam logic [1:0] STS_PULSE_WRITE = 2'h2;
   localparam logic [1:0] STS_PULSE_BOTH  = 2'h3;

   // bus timing
   localparam int CLK_MHZ       = 40;
   localparam int T_STROBE_NS   = 70;
   localparam int STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

   // user operations
   typedef enum logic [3:0] {
      OP_SUSPEND    = 4'h0,
      OP_RESUME     = 4'h1,
      OP_SET_LOCK   = 4'h2,
      OP_CLR_LOCKS  = 4'h3,
      OP_STS_CFG    = 4'h4,
      OP_RD_ARRAY   = 4'h5,
      OP_RD_STATUS  = 4'h6,
      OP_CLR_STATUS = 4'h7,
      OP_SET_PINS   = 4'h8
   } fsl_op_e;

   // sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_WR1  = 3'h1,
      S_WR2  = 3'h2,
      S_POLL = 3'h3,
      S_READ = 3'h4,
      S_CLR  = 3'h5,
      S_DONE = 3'h6
   } fsl_st_e;

   // bus cycle phases
   typedef enum logic [1:0] {
      PH_IDLE   = 2'h0,
      PH_SETUP  = 2'h1,
      PH_STROBE = 2'h2,
      PH_HOLD   = 2'h3
   } fsl_ph_e;
endpackage : fsl_pkg

// ==== hdl/fsl_cyc_if.sv ====
// request and answer of one flash bus cycle
// assumes the sequencer holds req until done and one cycle is open at a time
`timescale 1ns/1ps
interface fsl_cyc_if #(
   parameter int AW = 21,
   parameter int DW = 16
);
   logic          req;
   logic          wr;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic          done;
   logic [DW-1:0] rdata;

   modport seq (output req, wr, addr, wdata, input done, rdata);
   modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fsl_cyc_if

// ==== hdl/fsl_cycle.sv ====
// one asynchronous write or read cycle on the flash pins
// assumes pin inputs are synchronous to mclk
`timescale 1ns/1ps
module fsl_cycle #(
   parameter int AW = 21,
   parameter int DW = 16
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          arst_n,
   // sequencer side
   fsl_cyc_if.eng             cyc,
   // flash pins
   output logic               ce_n,
   output logic               we_n,
   output logic               oe_n,
   output logic [AW-1:0]      addr,
   input  wire logic [DW-1:0] dq_in,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe
);
   typedef struct packed {
      fsl_pkg::fsl_ph_e ph;
      logic [7:0]       cnt;
      logic             wr;
      logic             ce_n;
      logic             we_n;
      logic             oe_n;
      logic [AW-1:0]    addr;
      logic [DW-1:0]    dq_o;
      logic             dq_oe;
      logic [DW-1:0]    rdata;
      logic             done;
   } fsl_cyc_s;

   fsl_cyc_s q;
   fsl_cyc_s d;

   // refuse a strobe that cannot be counted
   if (fsl_pkg::STROBE_CYC < 1 || fsl_pkg::STROBE_CYC > 256) begin : g_chk
      $error("strobe length out of range");
   end

   // cycle phases: setup, strobe, hold
   always_comb begin
      d      = q;
      d.done = 1'b0;
      unique case (q.ph)
         fsl_pkg::PH_IDLE: begin
            if (cyc.req && !q.done) begin
               d.ph    = fsl_pkg::PH_SETUP;
               d.cnt   = 8'h00;
               d.wr    = cyc.wr;
               d.ce_n  = 1'b0;
               d.addr  = cyc.addr;
               d.dq_o  = cyc.wdata;
               d.dq_oe = cyc.wr;
            end
         end
         fsl_pkg::PH_SETUP: begin
            d.ph   = fsl_pkg::PH_STROBE;
            d.we_n = !q.wr;
            d.oe_n = q.wr;
         end
         fsl_pkg::PH_STROBE: begin
            d.cnt = q.cnt + 8'h01;
            if (q.cnt == fsl_pkg::STROBE_LAST) begin
               d.ph    = fsl_pkg::PH_HOLD;
               d.we_n  = 1'b1;             // data latched on rising edge
               d.oe_n  = 1'b1;
               d.rdata = dq_in;            // sample before output disable
            end
         end
         fsl_pkg::PH_HOLD: begin
            d.ph    = fsl_pkg::PH_IDLE;
            d.ce_n  = 1'b1;
            d.dq_oe = 1'b0;
            d.done  = 1'b1;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{ph: fsl_pkg::PH_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   assign cyc.done  = q.done;
   assign cyc.rdata = q.rdata;
   assign ce_n      = q.ce_n;
   assign we_n      = q.we_n;
   assign oe_n      = q.oe_n;
   assign addr      = q.addr;
   assign dq_out    = q.dq_o;
   assign dq_oe     = q.dq_oe;
endmodule : fsl_cycle

// ==== hdl/fsl_host.sv ====
// host sequencer for suspend/resume, protection bits and status pin setup
// assumes the flash status pin is pulled up externally and sampled as a level
`timescale 1ns/1ps
module fsl_host #(
   parameter int         AW          = 21,
   parameter int         DW          = 16,
   parameter int         POLL_MAX    = 4000,
   parameter logic [7:0] CMD_SUSPEND = 8'hB0,
   parameter logic [7:0] CMD_RESUME  = 8'hD0,
   parameter logic [7:0] CMD_LOCK_SU = 8'h60,
   parameter logic [7:0] CMD_SET_CF  = 8'h01,
   parameter logic [7:0] CMD_CLR_CF  = 8'hD0,
   parameter logic [7:0] CMD_STS_CFG = 8'hB8,
   parameter logic [7:0] CMD_RD_ARR  = 8'hFF,
   parameter logic [7:0] CMD_RD_STAT = 8'h70,
   parameter logic [7:0] CMD_CLR_ST  = 8'h50
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          arst_n,
   // user command port
   input  wire logic          cmd_valid,
   input  wire logic [3:0]    cmd_op,
   input  wire logic [AW-1:0] cmd_addr,
   input  wire logic [7:0]    cmd_data,
   output logic               cmd_ready,
   output logic               cmd_done,
   output logic               cmd_refused,
   output logic               cmd_fail,
   output logic               cmd_timeout,
   output logic [7:0]         status_byte,
   output logic [DW-1:0]      read_data,
   output logic               suspended,
   output logic               lock_unknown,
   output logic [1:0]         sts_mode,
   output logic               sts_busy,
   output logic               sts_event,
   // flash pins
   output logic               ce_n,
   output logic               we_n,
   output logic               oe_n,
   output logic [AW-1:0]      addr,
   input  wire logic [DW-1:0] dq_in,
   output logic [DW-1:0]      dq_out,
   output logic               dq_oe,
   output logic               rp_n,
   output logic               wp_n,
   output logic               byte_n,
   input  wire logic          sts_pin
);
   typedef struct packed {
      fsl_pkg::fsl_st_e st;
      fsl_pkg::fsl_op_e op;
      logic [AW-1:0]    addr;
      logic [7:0]       data;
      logic [7:0]       stat;
      logic [DW-1:0]    rdata;
      logic [15:0]      poll_cnt;
      logic             susp;
      logic [AW-1:0]    susp_addr;
      logic [1:0]       sts_mode;
      logic             lock_unk;
      logic             rp_n;
      logic             wp_n;
      logic             byte_n;
      logic             done;
      logic             refused;
      logic             fail;
      logic             tmo;
      logic             sts_prev;
      logic             sts_busy;
      logic             sts_evt;
      logic             ready;
   } fsl_host_s;

   fsl_host_s q;
   fsl_host_s d;

   fsl_cyc_if #(.AW(AW), .DW(DW)) cyc ();

   // refuse a poll bound the counter cannot hold
   if (POLL_MAX < 1 || POLL_MAX > 65535 || DW < 8) begin : g_chk
      $error("poll bound or data width out of range");
   end

   fsl_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .mclk   (mclk),
      .arst_n (arst_n),
      .cyc    (cyc.eng),
      .ce_n   (ce_n),
      .we_n   (we_n),
      .oe_n   (oe_n),
      .addr   (addr),
      .dq_in  (dq_in),
      .dq_out (dq_out),
      .dq_oe  (dq_oe)
   );

   // bus cycle request from the sequencer state
   always_comb begin
      cyc.req   = 1'b0;
      cyc.wr    = 1'b1;
      cyc.addr  = q.addr;
      cyc.wdata = '0;
      unique case (q.st)
         fsl_pkg::S_WR1: begin
            cyc.req = 1'b1;
            unique case (q.op)
               fsl_pkg::OP_SUSPEND:  cyc.wdata[7:0] = CMD_SUSPEND;
               fsl_pkg::OP_RESUME:   cyc.wdata[7:0] = CMD_RESUME;
               fsl_pkg::OP_STS_CFG:  cyc.wdata[7:0] = CMD_STS_CFG;
               fsl_pkg::OP_RD_ARRAY: cyc.wdata[7:0] = CMD_RD_ARR;
               fsl_pkg::OP_RD_STATUS: cyc.wdata[7:0] = CMD_RD_STAT;
               fsl_pkg::OP_CLR_STATUS: cyc.wdata[7:0] = CMD_CLR_ST;
               default:              cyc.wdata[7:0] = CMD_LOCK_SU;
            endcase
         end
         fsl_pkg::S_WR2: begin
            cyc.req = 1'b1;
            unique case (q.op)
               fsl_pkg::OP_SET_LOCK: cyc.wdata[7:0] = CMD_SET_CF;
               fsl_pkg::OP_CLR_LOCKS: cyc.wdata[7:0] = CMD_CLR_CF;
               default:              cyc.wdata[7:0] = {6'h00, q.data[1:0]};
            endcase
         end
         fsl_pkg::S_POLL, fsl_pkg::S_READ: begin
            cyc.req = 1'b1;
            cyc.wr  = 1'b0;
         end
         fsl_pkg::S_CLR: begin
            cyc.req        = 1'b1;
            cyc.wdata[7:0] = CMD_CLR_ST;
         end
         default: ;
      endcase
   end

   // sequencer
   always_comb begin
      d         = q;
      d.done    = 1'b0;
      d.sts_evt = 1'b0;
      // status pin: low is busy in level mode, low pulse ends in pulse modes
      d.sts_prev = sts_pin;
      d.sts_busy = (q.sts_mode == fsl_pkg::STS_LEVEL) && !sts_pin;
      if (q.sts_mode != fsl_pkg::STS_LEVEL && !q.sts_prev && sts_pin) begin
         d.sts_evt = 1'b1;
      end
      unique case (q.st)
         fsl_pkg::S_IDLE: begin
            if (cmd_valid) begin
               d.op      = fsl_pkg::fsl_op_e'(cmd_op);
               d.addr    = cmd_addr;
               d.data    = cmd_data;
               d.refused = 1'b0;
               d.fail    = 1'b0;
               d.tmo     = 1'b0;
               d.st      = fsl_pkg::S_WR1;
               if (q.susp && !(cmd_op == fsl_pkg::OP_RD_STATUS
                     || cmd_op == fsl_pkg::OP_RESUME
                     || (cmd_op == fsl_pkg::OP_RD_ARRAY && cmd_addr != q.susp_addr))) begin
                  d.refused = 1'b1;
               end
               if (!q.susp && cmd_op == fsl_pkg::OP_RESUME) begin
                  d.refused = 1'b1;
               end
               if (!q.rp_n && cmd_op != fsl_pkg::OP_SET_PINS) begin
                  d.refused = 1'b1;
               end
               if (cmd_op > fsl_pkg::OP_SET_PINS) d.refused = 1'b1;
               if (d.refused) begin
                  d.st = fsl_pkg::S_DONE;
               end else if (cmd_op == fsl_pkg::OP_SET_PINS) begin
                  // pins frozen during suspend, refused above
                  d.wp_n   = cmd_data[0];
                  d.byte_n = cmd_data[1];
                  d.rp_n   = cmd_data[2];
                  // reset/power-down low drops the pin mode
                  if (!cmd_data[2]) begin
                     d.sts_mode = fsl_pkg::STS_LEVEL;
                  end
                  d.st = fsl_pkg::S_DONE;
               end else if (cmd_op == fsl_pkg::OP_CLR_LOCKS) begin
                  // unknown until a clear completes cleanly
                  d.lock_unk = 1'b1;
               end
            end
         end
         fsl_pkg::S_WR1: begin
            if (cyc.done) begin
               d.poll_cnt = 16'h0000;
               unique case (q.op)
                  fsl_pkg::OP_SET_LOCK, fsl_pkg::OP_CLR_LOCKS,
                  fsl_pkg::OP_STS_CFG: d.st = fsl_pkg::S_WR2;
                  fsl_pkg::OP_RD_ARRAY, fsl_pkg::OP_RD_STATUS: d.st = fsl_pkg::S_READ;
                  fsl_pkg::OP_CLR_STATUS: d.st = fsl_pkg::S_DONE;
                  default: d.st = fsl_pkg::S_POLL;
               endcase
               // resume: the write continues, suspension is over
               if (q.op == fsl_pkg::OP_RESUME) begin
                  d.susp = 1'b0;
               end
            end
         end
         fsl_pkg::S_WR2: begin
            if (cyc.done) begin
               if (q.op == fsl_pkg::OP_STS_CFG) begin
                  d.sts_mode = q.data[1:0];
                  d.st       = fsl_pkg::S_DONE;
               end else begin
                  // device now returns status on reads
                  d.st = fsl_pkg::S_POLL;
               end
            end
         end
         fsl_pkg::S_POLL: begin
            if (cyc.done) begin
               d.stat     = cyc.rdata[7:0];
               d.poll_cnt = q.poll_cnt + 16'h0001;
               if (cyc.rdata[fsl_pkg::BIT_READY]) begin
                  d.st = fsl_pkg::S_DONE;
                  // ready plus suspended means the write is parked
                  if (q.op == fsl_pkg::OP_SUSPEND) begin
                     d.susp      = cyc.rdata[fsl_pkg::BIT_WR_SUSP];
                     d.susp_addr = q.addr;
                  end
                  // program error after set protection bit
                  if (q.op == fsl_pkg::OP_SET_LOCK && cyc.rdata[fsl_pkg::BIT_PROG_ERR]) begin
                     d.fail = 1'b1;
                     d.st   = fsl_pkg::S_CLR;
                  end
                  if (q.op == fsl_pkg::OP_CLR_LOCKS) begin
                     if (cyc.rdata[fsl_pkg::BIT_ERASE_ERR]) begin
                        d.fail = 1'b1;
                        d.st   = fsl_pkg::S_CLR;
                     end else begin
                        d.lock_unk = 1'b0;
                     end
                  end
               end else if (q.poll_cnt == 16'(POLL_MAX - 1)) begin
                  d.tmo = 1'b1;
                  d.st  = fsl_pkg::S_DONE;
               end
            end
         end
         fsl_pkg::S_READ: begin
            if (cyc.done) begin
               d.rdata = cyc.rdata;
               if (q.op == fsl_pkg::OP_RD_STATUS) begin
                  d.stat = cyc.rdata[7:0];
               end
               d.st = fsl_pkg::S_DONE;
            end
         end
         fsl_pkg::S_CLR: begin
            if (cyc.done) d.st = fsl_pkg::S_DONE;
         end
         fsl_pkg::S_DONE: begin
            d.done = 1'b1;
            d.st   = fsl_pkg::S_IDLE;
         end
         default: d.st = fsl_pkg::S_IDLE;
      endcase
      d.ready = (d.st == fsl_pkg::S_IDLE);
   end

   // state register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{st: fsl_pkg::S_IDLE, op: fsl_pkg::OP_SUSPEND, sts_mode: fsl_pkg::STS_LEVEL,
                rp_n: 1'b1, wp_n: 1'b1, byte_n: 1'b1, sts_prev: 1'b1, ready: 1'b1, default: '0};
      end else begin
         q <= d;
      end
   end

   // user outputs straight from the state register
   assign cmd_ready    = q.ready;
   assign cmd_done     = q.done;
   assign cmd_refused  = q.refused;
   assign cmd_fail     = q.fail;
   assign cmd_timeout  = q.tmo;
   assign status_byte  = q.stat;
   assign read_data    = q.rdata;
   assign suspended    = q.susp;
   assign lock_unknown = q.lock_unk;
   assign sts_mode     = q.sts_mode;
   assign sts_busy     = q.sts_busy;
   assign sts_event    = q.sts_evt;
   assign rp_n         = q.rp_n;
   assign wp_n         = q.wp_n;
   assign byte_n       = q.byte_n;
endmodule : fsl_host

// ==== verif/fsl_host_sva.sv ====
// port checks for the flash host controller
// assumes a bind onto fsl_host from the testbench
`timescale 1ns/1ps
module fsl_host_sva (
   // clock and reset
   input wire logic       mclk, arst_n,
   // user port
   input wire logic       cmd_valid, cmd_ready, cmd_done, cmd_refused,
   input wire logic [3:0] cmd_op,
   input wire logic [7:0] cmd_data, status_byte,
   input wire logic       suspended, sts_busy, sts_event,
   input wire logic [1:0] sts_mode,
   // flash pins
   input wire logic       ce_n, we_n, dq_oe, rp_n, wp_n, byte_n, sts_pin
);
   logic       take;
   logic [3:0] op_q;
   logic [7:0] dat_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // last accepted command
   assign take = cmd_valid && cmd_ready;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         op_q  <= 4'h0;
         dat_q <= 8'h00;
      end else if (take) begin
         op_q  <= cmd_op;
         dat_q <= cmd_data;
      end
   end
   property p_done_ready;
      cmd_done |-> cmd_ready ##1 !cmd_done;
   endproperty
   a_done_ready: assert property (p_done_ready) else $error("done width or ready");
   property p_susp_refuse;
      take && suspended && cmd_op == fsl_pkg::OP_SET_LOCK |=> ce_n ##1 cmd_done && cmd_refused;
   endproperty
   a_susp_refuse: assert property (p_susp_refuse) else $error("op taken in suspend");
   property p_pins_hold;
      suspended && $past(suspended) |-> $stable(wp_n) && $stable(byte_n) && rp_n;
   endproperty
   a_pins_hold: assert property (p_pins_hold) else $error("pins moved in suspend");
   property p_rp_level;
      !rp_n && !$past(rp_n) |-> sts_mode == fsl_pkg::STS_LEVEL;
   endproperty
   a_rp_level: assert property (p_rp_level) else $error("mode kept in power-down");
   property p_busy_lvl;
      sts_busy |-> $past(sts_mode) == fsl_pkg::STS_LEVEL && !$past(sts_pin);
   endproperty
   a_busy_lvl: assert property (p_busy_lvl) else $error("busy without cause");
   property p_evt;
      sts_event |-> sts_mode != fsl_pkg::STS_LEVEL ##1 !sts_event;
   endproperty
   a_evt: assert property (p_evt) else $error("bad status event");
   property p_wr_strobe;
      $fell(we_n) |-> (!we_n && !ce_n && dq_oe)[*3] ##1 (we_n && !ce_n);
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe shape");
   property p_cfg;
      cmd_done && !cmd_refused && op_q == fsl_pkg::OP_STS_CFG |-> sts_mode == dat_q[1:0];
   endproperty
   a_cfg: assert property (p_cfg) else $error("mode not from code");
   property p_susp_flag;
      cmd_done && !cmd_refused && op_q == fsl_pkg::OP_SUSPEND |-> suspended == status_byte[2];
   endproperty
   a_susp_flag: assert property (p_susp_flag) else $error("suspend flag");
   property p_take_rp;
      take && !rp_n && cmd_op != fsl_pkg::OP_SET_PINS |-> ##2 cmd_done && cmd_refused;
   endproperty
   a_take_rp: assert property (p_take_rp) else $error("op taken in power-down");
   c_susp: cover property ($rose(suspended));
   c_evt: cover property (sts_event);
   c_ref: cover property (cmd_done && cmd_refused);
endmodule : fsl_host_sva

// ==== verif/fsl_flash_model.sv ====
// behavioural flash device answering the host controller
// assumes pins change just after mclk edges; status pin has a pull-up
`timescale 1ns/1ps
module fsl_flash_model #(
   parameter int PULSE = 4
) (
   // timing clock
   input wire logic        mclk,
   // bus pins
   input wire logic        ce_n, we_n, oe_n, rp_n, wp_n,
   input wire logic [20:0] addr,
   input wire logic [15:0] dq_out,
   output logic [15:0]     dq_in,
   output logic            sts_pin,
   // test knobs
   input wire logic        vpp_low,
   input wire logic [7:0]  busy_len
);
   logic [7:0]  sr    = 8'h80;
   logic [1:0]  mode  = 2'h0;
   logic [1:0]  pend  = 2'h0;
   logic [1:0]  cls   = 2'h0;
   logic        rd_st = 1'b0;
   logic        we_q  = 1'b1;
   logic [15:0] last  = 16'h0000;
   int          cnt   = 0;
   int          pls   = 0;
   // selected: status or array pattern; else toggling junk
   assign dq_in = (!ce_n && !oe_n) ? (rd_st ? {8'h00, sr} : addr[15:0] ^ 16'hA5C3) : ~last;
   assign sts_pin = (mode == 2'h0) ? (cnt == 0) : (pls == 0);
   task automatic start(input logic [1:0] k);
      sr[7] <= 1'b0;
      cnt   <= int'(busy_len);
      cls   <= k;
   endtask : start
   task automatic cmd(input logic [7:0] c);
      rd_st <= 1'b1;
      pend  <= 2'h0;
      if (pend == 2'h1) begin
         if (c != 8'h01 && c != 8'hD0) sr <= sr | 8'h30;
         else if (!wp_n) sr <= sr | ((c == 8'h01) ? 8'h12 : 8'h22);
         else if (c == 8'hD0 && vpp_low) sr <= sr | 8'h28;
         else start((c == 8'h01) ? 2'h2 : 2'h1);
      end else if (pend == 2'h2) mode <= c[1:0];
      else case (c)
         8'h60: pend <= 2'h1;
         8'hB8: pend <= 2'h2;
         8'hFF: rd_st <= 1'b0;
         8'h50: sr <= sr & 8'hC1;
         8'hB0: sr <= sr | 8'h84;
         8'hD0: if (sr[2]) begin
            sr[2] <= 1'b0;
            start(2'h2);
         end
         default: ;
      endcase
   endtask : cmd
   // commands latch on the rising write strobe
   always @(posedge mclk) begin
      last <= dq_in;
      we_q <= we_n;
      if (!rp_n) begin
         mode  <= 2'h0;
         sr    <= 8'h80;
         cnt   <= 0;
         pend  <= 2'h0;
         rd_st <= 1'b0;
      end else begin
         if (pls > 0) pls <= pls - 1;
         if (cnt > 1) cnt <= cnt - 1;
         else if (cnt == 1) begin
            cnt   <= 0;
            sr[7] <= 1'b1;
            if ((mode & cls) != 2'h0) pls <= PULSE;
         end
         if (!ce_n && we_n && !we_q) cmd(dq_out[7:0]);
      end
   end
endmodule : fsl_flash_model

// ==== verif/testbench.sv ====
// self-checking bench for the flash host controller
// assumes the behavioural flash model on the far side
`timescale 1ns/1ps
module testbench;
   logic        mclk, arst_n, cmd_valid, vpp_low, cmd_ready, cmd_done, cmd_refused;
   logic        cmd_fail, cmd_timeout, suspended, lock_unknown, sts_busy, sts_event;
   logic        ce_n, we_n, oe_n, dq_oe, rp_n, wp_n, byte_n, sts_pin;
   logic [3:0]  cmd_op;
   logic [20:0] cmd_addr, addr;
   logic [7:0]  cmd_data, status_byte, busy_len;
   logic [15:0] read_data, dq_in, dq_out;
   logic [1:0]  sts_mode;
   int          n_errors = 0;
   int          checked = 0;
   int          cyc = 0;
   int          n_evt = 0, n_busy = 0;
   fsl_host #(.POLL_MAX(8)) dut_u (
      .mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
      .cmd_refused(cmd_refused), .cmd_fail(cmd_fail), .cmd_timeout(cmd_timeout),
      .status_byte(status_byte), .read_data(read_data), .suspended(suspended),
      .lock_unknown(lock_unknown), .sts_mode(sts_mode), .sts_busy(sts_busy),
      .sts_event(sts_event), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rp_n(rp_n), .wp_n(wp_n),
      .byte_n(byte_n), .sts_pin(sts_pin)
   );
   fsl_flash_model model_u (
      .mclk(mclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n), .wp_n(wp_n),
      .addr(addr), .dq_out(dq_out), .dq_in(dq_in), .sts_pin(sts_pin),
      .vpp_low(vpp_low), .busy_len(busy_len)
   );
   // clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // cycle ceiling and status pin activity
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sts_event === 1'b1) n_evt <= n_evt + 1;
      if (sts_busy === 1'b1) n_busy <= n_busy + 1;
      if (cyc == 30000) begin
         fail("run too long");
         finish_test();
      end
   end
   task automatic fail(input string m);
      $display("unexpected at %0t: %s", $time, m);
      n_errors++;
   endtask : fail
   task automatic chk_bit(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) fail(m);
   endtask : chk_bit
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp) fail(m);
   endtask : chk_val
   // one command: wait ready, offer it, wait for done
   task automatic run(input logic [3:0] op, input logic [20:0] a, input logic [7:0] d);
      for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      @(posedge mclk);
      #1 cmd_valid = 1'b0;
      for (int i = 0; i < 2000 && cmd_done !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      if (cmd_done !== 1'b1) fail("no done");
   endtask : run
   task automatic t_reset;
      chk_bit(cmd_ready, 1'b1, "ready after reset");
      chk_val(16'(sts_mode), 16'h0000, "mode after reset");
   endtask : t_reset
   task automatic t_suspend;
      int b0;
      busy_len = 8'h14;
      run(4'h0, 21'h00100, 8'h00);
      chk_val(16'(status_byte & 8'h84), 16'h0084, "suspend status");
      chk_bit(suspended, 1'b1, "not suspended");
      run(4'h2, 21'h10000, 8'h00);
      chk_bit(cmd_refused, 1'b1, "lock in suspend");
      run(4'h5, 21'h00100, 8'h00);
      chk_bit(cmd_refused, 1'b1, "suspended word");
      run(4'h8, 21'h00000, 8'h06);
      chk_bit(cmd_refused, 1'b1, "pins in suspend");
      run(4'h5, 21'h00200, 8'h00);
      chk_val(read_data, 16'h0200 ^ 16'hA5C3, "array data");
      b0 = n_busy;
      run(4'h1, 21'h00100, 8'h00);
      chk_bit(suspended | status_byte[2], 1'b0, "still suspended");
      chk_bit(n_busy > b0, 1'b1, "no resume busy");
      run(4'h1, 21'h00100, 8'h00);
      chk_bit(cmd_refused, 1'b1, "idle resume");
   endtask : t_suspend
   task automatic t_protect;
      run(4'h8, 21'h00000, 8'h06);
      run(4'h2, 21'h10000, 8'h00);
      chk_val(16'(status_byte & 8'h12), 16'h0012, "set with wp low");
      run(4'h3, 21'h00000, 8'h00);
      chk_val(16'(status_byte & 8'h22), 16'h0022, "clear with wp low");
      run(4'h8, 21'h00000, 8'h07);
      vpp_low = 1'b1;
      run(4'h3, 21'h00000, 8'h00);
      chk_val(16'(status_byte & 8'h28), 16'h0028, "low supply");
      chk_bit(cmd_fail & lock_unknown, 1'b1, "lock state");
      vpp_low = 1'b0;
      run(4'h3, 21'h00000, 8'h00);
      chk_bit(cmd_fail | lock_unknown, 1'b0, "clear retry");
      run(4'h6, 21'h00000, 8'h00);
      chk_val(16'(status_byte & 8'h3E), 16'h0000, "errors left");
   endtask : t_protect
   task automatic t_modes;
      int e0, b0;
      for (int k = 0; k < 4; k++) begin
         run(4'h4, 21'h00000, 8'(k));
         chk_val(16'(sts_mode), 16'(k), "mode code");
         e0 = n_evt;
         b0 = n_busy;
         run(4'h2, 21'h10000, 8'h00);
         chk_bit(cmd_fail | status_byte[4], 1'b0, "lock set");
         run(4'h3, 21'h00000, 8'h00);
         chk_bit(cmd_fail | lock_unknown, 1'b0, "lock clear");
         repeat (12) @(posedge mclk);
         #1;
         chk_val(16'(n_evt - e0), 16'(k % 2 + k / 2), "pulse count");
         chk_bit(n_busy > b0, k == 0, "level busy");
      end
   endtask : t_modes
   task automatic t_power;
      run(4'h8, 21'h00000, 8'h03);
      chk_val(16'(sts_mode), 16'h0000, "mode in power-down");
      run(4'h4, 21'h00000, 8'h01);
      chk_bit(cmd_refused, 1'b1, "config in power-down");
      run(4'h8, 21'h00000, 8'h07);
      run(4'h9, 21'h00000, 8'h00);
      chk_bit(cmd_refused, 1'b1, "unknown op");
      busy_len = 8'hFF;
      run(4'h3, 21'h00000, 8'h00);
      chk_bit(cmd_timeout & lock_unknown, 1'b1, "poll bound");
   endtask : t_power
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      arst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = 4'h0;
      cmd_addr = 21'h00000;
      cmd_data = 8'h00;
      vpp_low = 1'b0;
      busy_len = 8'h02;
      repeat (6) @(posedge mclk);
      #1 arst_n = 1'b1;
      t_reset();
      t_suspend();
      t_protect();
      t_modes();
      t_power();
      finish_test();
   end
endmodule : testbench
bind fsl_host fsl_host_sva sva_u (
   .mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .cmd_done(cmd_done), .cmd_refused(cmd_refused), .cmd_op(cmd_op), .cmd_data(cmd_data),
   .status_byte(status_byte), .suspended(suspended), .sts_busy(sts_busy),
   .sts_event(sts_event), .sts_mode(sts_mode), .ce_n(ce_n), .we_n(we_n), .dq_oe(dq_oe),
   .rp_n(rp_n), .wp_n(wp_n), .byte_n(byte_n), .sts_pin(sts_pin)
);
